// file: common/tcc_params.svh
// Purpose: Offsets, field positions and reset values of the transceive control block
// Assumes: Printed offsets are word indices; byte address is four times the index
// Notes: Included by the design files
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

`define TCC_IDX_IRQ_EN 6'h01
`define TCC_IDX_IRQ_STAT 6'h02
`define TCC_IDX_IRQ_CLR 6'h03
`define TCC_IDX_XCV_CTRL 6'h04

`define TCC_CTRL_INIT_BIT 0
`define TCC_CTRL_RPT_BIT 1
`define TCC_CTRL_STEP_BIT 2
`define TCC_CTRL_SKIP_BIT 3
`define TCC_CTRL_SEL_LO 4
`define TCC_CTRL_SEL_HI 9
`define TCC_CTRL_RESET 10'h000

`define TCC_IRQ_RX_END_BIT 0
`define TCC_IRQ_TX_END_BIT 1
`define TCC_IRQ_STATE_BIT 5
`define TCC_IRQ_WIDTH 6
`define TCC_IRQ_RESET 6'h00

`define TCC_PAD_BYTE 8'h00
`define TCC_ADDR_RESET 8'h00

`endif

// file: common/tcc_pkg.sv
// Purpose: Types shared by the transceive control block
// Assumes: Constants live in tcc_params.svh
// Notes: One-hot sequencer state codes, bit i matches selection bit i
package tcc_pkg;

    typedef enum logic [5:0] {
        TCC_IDLE = 6'h01,
        TCC_PRE_SEND = 6'h02,
        TCC_TRANSMIT = 6'h04,
        TCC_PRE_RECV = 6'h08,
        TCC_AWAIT = 6'h10,
        TCC_RECEIVE = 6'h20
    } tcc_seq_e;

    typedef struct packed {
        logic [23:0] held;
        logic [1:0] cnt;
        logic [7:0] addr;
        logic we;
        logic [7:0] waddr;
        logic [31:0] wdata;
    } tcc_pack_s;

endpackage : tcc_pkg

// file: core/tcc_transceive_ctrl.sv
// Purpose: Transceive sequencer control with APB registers and interrupt
// Assumes: All inputs synchronous to clk; encoder and receiver outside
// Notes: Registers at byte address four times the word index
// Functional notes
// (RULE_01) Six-bit state select field at bits 9:4, reset zero, any combination allowed.
// (RULE_02) All select bits zero means the state change flag never sets.
// (RULE_03) Select bit 0 idle, bit 1 pre-send wait, bit 2 transmitting.
// (RULE_04) Select bit 3 pre-receive wait, bit 4 await frame, bit 5 receiving.
// (RULE_05) Skip bit 3 set: guard expiry plus send request starts no transmission.
// (RULE_06) Hardware clears skip bit on entering pre-receive wait.
// (RULE_07) Framestep bit 2 set: each byte is sent as its own frame.
// (RULE_08) In framestep every byte carries start and end of frame marks.
// (RULE_09) In framestep encoder pauses after each byte until a fresh send trigger.
// (RULE_10) Repeat bit 1 set: receiver rearmed after each reception ends.
// (RULE_11) In repeat mode one status byte per frame is written to RAM.
// (RULE_12) Frames stored word-aligned, partial words padded with zero bytes.
// (RULE_13) Software computes each next frame's RAM start address itself; here the packer begins at word 0 on transceive start and goes on after each frame.
// (RULE_14) Initiator bit 0 selects initiator role, changing transceive sequence.
// (RULE_15) State change event shows as read-only status bit 5.
// (RULE_16) Enable bit 5 gates state change onto interrupt pin, reset zero.
// (RULE_17) Writing one to clear register bit 5 clears the status bit.
// (RULE_18) Flag sets on the cycle a selected state is entered only.
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_transceive_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic transceive_start,
    input wire logic transceive_stop,
    input wire logic send_request,
    input wire logic tx_guard_done,
    input wire logic rx_guard_done,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic enc_start,
    output logic [7:0] enc_data,
    output logic enc_sof,
    output logic enc_eof,
    input wire logic enc_done,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    input wire logic [7:0] rx_status,
    output logic ram_we,
    output logic [7:0] ram_addr,
    output logic [31:0] ram_wdata,
    output logic [5:0] seq_state,
    output logic initiator_mode
);

    typedef struct packed {
        logic [5:0] sel;
        logic skip;
        logic step;
        logic rpt;
        logic init;
        logic [`TCC_IRQ_WIDTH-1:0] irq_en;
        logic [`TCC_IRQ_WIDTH-1:0] irq_stat;
        tcc_pkg::tcc_seq_e state;
        logic send_prev;
        logic busy;
        logic first;
        logic last_sent;
        logic enc_start;
        logic [7:0] enc_data;
        logic enc_sof;
        logic enc_eof;
        logic [31:0] rdata;
    } tcc_top_s;

    tcc_top_s s_r;
    tcc_top_s s_nxt;

    logic send_trig;
    logic mapped;
    logic wr_en;
    logic pk_valid;
    logic [7:0] pk_byte;
    logic pk_last;
    logic pk_flush;
    logic pk_restart;

    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        return addr[7:2];
    endfunction : reg_index

    function automatic logic is_mapped(input logic [7:0] addr);
        logic [5:0] i;
        i = reg_index(addr);
        return (addr[1:0] == 2'h0) && (i == `TCC_IDX_IRQ_EN || i == `TCC_IDX_IRQ_STAT
            || i == `TCC_IDX_IRQ_CLR || i == `TCC_IDX_XCV_CTRL);
    endfunction : is_mapped

    // Zero wait states: read data is captured in the setup cycle
    assign mapped = is_mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign send_trig = send_request && !s_r.send_prev;
    assign tx_ready = (s_r.state == tcc_pkg::TCC_TRANSMIT) && !s_r.busy && !s_r.last_sent;

    always_comb begin
        tcc_pkg::tcc_seq_e go;
        go = s_r.state;
        s_nxt = s_r;
        s_nxt.enc_start = 1'b0;
        s_nxt.send_prev = send_request;

        // Register writes first, hardware updates below override them
        if (wr_en) begin
            case (reg_index(paddr))
                `TCC_IDX_XCV_CTRL: begin
                    s_nxt.sel = pwdata[`TCC_CTRL_SEL_HI:`TCC_CTRL_SEL_LO]; // RULE_01
                    s_nxt.skip = pwdata[`TCC_CTRL_SKIP_BIT];
                    s_nxt.step = pwdata[`TCC_CTRL_STEP_BIT];
                    s_nxt.rpt = pwdata[`TCC_CTRL_RPT_BIT];
                    s_nxt.init = pwdata[`TCC_CTRL_INIT_BIT];
                end
                `TCC_IDX_IRQ_EN: begin
                    s_nxt.irq_en = pwdata[`TCC_IRQ_WIDTH-1:0];
                end
                `TCC_IDX_IRQ_CLR: begin
                    s_nxt.irq_stat = s_r.irq_stat & ~pwdata[`TCC_IRQ_WIDTH-1:0]; // RULE_17
                end
                default: begin
                end
            endcase
        end

        if (transceive_stop) begin
            go = tcc_pkg::TCC_IDLE;
        end else begin
            case (s_r.state)
                tcc_pkg::TCC_IDLE: begin
                    if (transceive_start) begin
                        // Initiator sends first, target listens first
                        go = s_r.init ? tcc_pkg::TCC_PRE_SEND : tcc_pkg::TCC_PRE_RECV; // RULE_14
                        s_nxt.first = 1'b1;
                        s_nxt.last_sent = 1'b0;
                    end
                end
                tcc_pkg::TCC_PRE_SEND: begin
                    if (tx_guard_done && send_trig) begin
                        go = s_r.skip ? tcc_pkg::TCC_PRE_RECV : tcc_pkg::TCC_TRANSMIT; // RULE_05
                    end
                end
                tcc_pkg::TCC_TRANSMIT: begin
                    if (!s_r.busy && tx_valid && !s_r.last_sent) begin
                        s_nxt.enc_start = 1'b1;
                        s_nxt.enc_data = tx_data;
                        s_nxt.enc_sof = s_r.first || s_r.step; // RULE_08
                        s_nxt.enc_eof = tx_last || s_r.step; // RULE_08
                        s_nxt.busy = 1'b1;
                        s_nxt.first = 1'b0;
                        s_nxt.last_sent = tx_last;
                    end else if (s_r.busy && enc_done) begin
                        s_nxt.busy = 1'b0;
                        if (s_r.last_sent) begin
                            go = tcc_pkg::TCC_PRE_RECV;
                            s_nxt.irq_stat[`TCC_IRQ_TX_END_BIT] = 1'b1;
                        end else if (s_r.step) begin
                            // Pause until the next fresh send trigger
                            go = tcc_pkg::TCC_PRE_SEND; // RULE_07 RULE_09
                        end
                    end
                end
                tcc_pkg::TCC_PRE_RECV: begin
                    if (rx_guard_done) begin
                        go = tcc_pkg::TCC_AWAIT;
                    end
                end
                tcc_pkg::TCC_AWAIT: begin
                    if (rx_valid) begin
                        go = tcc_pkg::TCC_RECEIVE;
                    end
                end
                tcc_pkg::TCC_RECEIVE: begin
                    if (rx_end) begin
                        s_nxt.irq_stat[`TCC_IRQ_RX_END_BIT] = 1'b1;
                        if (s_r.rpt) begin
                            go = tcc_pkg::TCC_AWAIT; // RULE_10
                        end else if (s_r.init) begin
                            go = tcc_pkg::TCC_IDLE;
                        end else begin
                            go = tcc_pkg::TCC_PRE_SEND;
                            s_nxt.first = 1'b1;
                            s_nxt.last_sent = 1'b0;
                        end
                    end
                end
                default: begin
                    go = tcc_pkg::TCC_IDLE;
                end
            endcase
        end
        s_nxt.state = go;

        if (go == tcc_pkg::TCC_PRE_RECV && s_r.state != tcc_pkg::TCC_PRE_RECV) begin
            s_nxt.skip = 1'b0; // RULE_06
        end
        // Entry pulse only; one-hot code lines up with the select bits
        if (go != s_r.state && (s_r.sel & go) != 6'h00) begin
            s_nxt.irq_stat[`TCC_IRQ_STATE_BIT] = 1'b1; // RULE_02 RULE_03 RULE_04 RULE_18
        end

        if (psel && !penable) begin
            s_nxt.rdata = 32'h00000000;
            // Unmapped or unaligned reads return zero
            case (mapped ? reg_index(paddr) : 6'h00)
                `TCC_IDX_XCV_CTRL: begin
                    s_nxt.rdata[`TCC_CTRL_SEL_HI:0] = {s_r.sel, s_r.skip, s_r.step, s_r.rpt, s_r.init};
                end
                `TCC_IDX_IRQ_EN: begin
                    s_nxt.rdata[`TCC_IRQ_WIDTH-1:0] = s_r.irq_en;
                end
                `TCC_IDX_IRQ_STAT: begin
                    s_nxt.rdata[`TCC_IRQ_WIDTH-1:0] = s_r.irq_stat; // RULE_15
                end
                default: begin
                    s_nxt.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.state <= tcc_pkg::TCC_IDLE;
            s_r.first <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Status byte closes each frame only when rearming
    assign pk_restart = (s_r.state == tcc_pkg::TCC_IDLE) && transceive_start;
    assign pk_valid = (s_r.state == tcc_pkg::TCC_RECEIVE) && ((rx_valid && !rx_end) || (rx_end && s_r.rpt));
    assign pk_byte = rx_end ? rx_status : rx_data; // RULE_11
    assign pk_last = rx_end;
    assign pk_flush = (s_r.state == tcc_pkg::TCC_RECEIVE) && rx_end && !s_r.rpt;

    tcc_word_packer u_packer (
        .clk(clk),
        .reset_n(reset_n),
        .restart(pk_restart),
        .in_valid(pk_valid),
        .in_byte(pk_byte),
        .in_last(pk_last),
        .flush(pk_flush),
        .ram_we(ram_we),
        .ram_addr(ram_addr),
        .ram_wdata(ram_wdata)
    );

    assign prdata = s_r.rdata;
    assign irq = |(s_r.irq_stat & s_r.irq_en); // RULE_16
    assign enc_start = s_r.enc_start;
    assign enc_data = s_r.enc_data;
    assign enc_sof = s_r.enc_sof;
    assign enc_eof = s_r.enc_eof;
    assign seq_state = s_r.state;
    assign initiator_mode = s_r.init; // RULE_14

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_sel_zero_quiet: assert property ( // RULE_02
        (s_r.sel == 6'h00 && !s_r.irq_stat[`TCC_IRQ_STATE_BIT] && !wr_en)
            |=> !s_r.irq_stat[`TCC_IRQ_STATE_BIT])
        else $error("state change flag set with empty selection");

    a_entry_sets_flag: assert property ( // RULE_18
        (s_nxt.state != s_r.state && (s_r.sel & s_nxt.state) != 6'h00)
            |=> s_r.irq_stat[`TCC_IRQ_STATE_BIT])
        else $error("selected state entered without flag");

    a_stay_no_set: assert property ( // RULE_18
        (s_nxt.state == s_r.state && !s_r.irq_stat[`TCC_IRQ_STATE_BIT])
            |=> !s_r.irq_stat[`TCC_IRQ_STATE_BIT])
        else $error("flag rose while state held");

    a_skip_cleared: assert property ( // RULE_06
        $rose(s_r.state == tcc_pkg::TCC_PRE_RECV) |-> !s_r.skip)
        else $error("skip bit survived entry to pre-receive wait");

    a_skip_no_tx: assert property ( // RULE_05
        (s_r.state == tcc_pkg::TCC_PRE_SEND && s_r.skip && !transceive_stop && tx_guard_done && send_trig)
            |=> s_r.state == tcc_pkg::TCC_PRE_RECV && !s_r.enc_start)
        else $error("transmission started while skip set");

    a_step_frames: assert property ( // RULE_08
        (s_r.enc_start && s_r.step) |-> (s_r.enc_sof && s_r.enc_eof))
        else $error("framestep byte lacks frame marks");

    a_step_pause: assert property ( // RULE_09
        (s_r.state == tcc_pkg::TCC_TRANSMIT && s_r.busy && enc_done && s_r.step && !s_r.last_sent
            && !transceive_stop) |=> s_r.state == tcc_pkg::TCC_PRE_SEND ##1 !s_r.enc_start)
        else $error("framestep did not pause after byte");

    a_irq_gate: assert property ( // RULE_16
        (s_r.irq_stat[`TCC_IRQ_STATE_BIT] && (s_r.irq_stat & s_r.irq_en & 6'h1f) == 6'h00)
            |-> irq == s_r.irq_en[`TCC_IRQ_STATE_BIT])
        else $error("interrupt does not follow state change enable");

    a_clear_works: assert property ( // RULE_17
        (wr_en && reg_index(paddr) == `TCC_IDX_IRQ_CLR && pwdata[`TCC_IRQ_STATE_BIT]
            && !(s_nxt.state != s_r.state && (s_r.sel & s_nxt.state) != 6'h00))
            |=> !s_r.irq_stat[`TCC_IRQ_STATE_BIT])
        else $error("state change flag not cleared");

    a_rearm: assert property ( // RULE_10
        (s_r.state == tcc_pkg::TCC_RECEIVE && rx_end && s_r.rpt && !transceive_stop)
            |=> s_r.state == tcc_pkg::TCC_AWAIT)
        else $error("receiver not rearmed");

    a_role_entry: assert property ( // RULE_14
        (s_r.state == tcc_pkg::TCC_IDLE && transceive_start && !transceive_stop)
            |=> s_r.state == ($past(s_r.init) ? tcc_pkg::TCC_PRE_SEND : tcc_pkg::TCC_PRE_RECV))
        else $error("wrong first state for role");

endmodule : tcc_transceive_ctrl

// file: core/tcc_word_packer.sv
// Purpose: Packs received bytes into aligned RAM words
// Assumes: At most one byte or flush per cycle
// Notes: A partial word is written with zero padding bytes
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_word_packer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_last,
    input wire logic flush,
    output logic ram_we,
    output logic [7:0] ram_addr,
    output logic [31:0] ram_wdata
);

    tcc_pkg::tcc_pack_s s_r;
    tcc_pkg::tcc_pack_s s_nxt;

    function automatic logic [31:0] pad_word(input logic [23:0] held, input logic [1:0] cnt);
        logic [31:0] w;
        w = {`TCC_PAD_BYTE, `TCC_PAD_BYTE, `TCC_PAD_BYTE, `TCC_PAD_BYTE};
        case (cnt)
            2'h1: w[7:0] = held[7:0];
            2'h2: w[15:0] = held[15:0];
            2'h3: w[23:0] = held;
            default: w = {`TCC_PAD_BYTE, `TCC_PAD_BYTE, `TCC_PAD_BYTE, `TCC_PAD_BYTE};
        endcase
        return w;
    endfunction : pad_word

    always_comb begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        if (restart) begin
            s_nxt.addr = `TCC_ADDR_RESET;
            s_nxt.cnt = 2'h0;
        end else if (in_valid) begin
            if (s_r.cnt == 2'h3) begin
                s_nxt.we = 1'b1;
                s_nxt.waddr = s_r.addr;
                s_nxt.wdata = {in_byte, s_r.held};
                s_nxt.addr = s_r.addr + 8'h01;
                s_nxt.cnt = 2'h0;
            end else if (in_last) begin
                // Last byte of a frame closes the word with padding
                s_nxt.we = 1'b1;
                s_nxt.waddr = s_r.addr;
                s_nxt.wdata = pad_word(s_r.held, s_r.cnt) | ({24'h000000, in_byte} << {s_r.cnt, 3'h0}); // RULE_12
                s_nxt.addr = s_r.addr + 8'h01;
                s_nxt.cnt = 2'h0;
            end else begin
                s_nxt.held[{s_r.cnt, 3'h0} +: 8] = in_byte;
                s_nxt.cnt = s_r.cnt + 2'h1;
            end
        end else if (flush && s_r.cnt != 2'h0) begin
            s_nxt.we = 1'b1;
            s_nxt.waddr = s_r.addr;
            s_nxt.wdata = pad_word(s_r.held, s_r.cnt); // RULE_12
            s_nxt.addr = s_r.addr + 8'h01;
            s_nxt.cnt = 2'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ram_we = s_r.we;
    assign ram_addr = s_r.waddr;
    assign ram_wdata = s_r.wdata;

endmodule : tcc_word_packer

// file: tb/tcc_far_model.sv
// Purpose: Behavioural transmit encoder standing beyond the control block
// Assumes: One byte in flight at a time
// Notes: DLY sets how slowly each byte is answered
`timescale 1ns/1ps
module tcc_far_model #(
    parameter int DLY = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enc_start,
    input wire logic [7:0] enc_data,
    input wire logic enc_sof,
    input wire logic enc_eof,
    output logic enc_done,
    output int frames,
    output logic [7:0] last_byte
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 4'h0;
            enc_done <= 1'b0;
            frames <= 0;
            last_byte <= 8'h00;
        end else begin
            enc_done <= 1'b0;
            if (enc_start) begin
                cnt_r <= 4'(DLY);
                last_byte <= enc_data;
                // Only a byte wrapped in both marks counts as a frame
                if (enc_sof && enc_eof) begin
                    frames <= frames + 1;
                end
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
                enc_done <= (cnt_r == 4'h1);
            end
        end
    end
endmodule : tcc_far_model

// file: tb/tcc_transceive_ctrl_tb.sv
// Purpose: Self-checking bench for the transceive control block
// Assumes: Encoder answered by tcc_far_model, receiver bytes driven here
// Notes: Register accesses through APB, byte address four times the index
`timescale 1ns/1ps
module tcc_transceive_ctrl_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tcc_row_s;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr, td, edat, rd, rs, wa, lastb;
    logic [31:0] pwdata, prdata, wd, r;
    logic start, stop, sreq, tg, rg, tv, tl, txr, es, esof, eeof, ed, rv, re, we, init;
    logic [5:0] st;
    int fail_count, comparisons, cycles, f0, frames;
    logic [39:0] ram_q[$];
    tcc_row_s rows[13];

    tcc_transceive_ctrl u_tcc_transceive_ctrl (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .transceive_start(start), .transceive_stop(stop), .send_request(sreq), .tx_guard_done(tg),
        .rx_guard_done(rg), .tx_valid(tv), .tx_data(td), .tx_last(tl), .tx_ready(txr), .enc_start(es),
        .enc_data(edat), .enc_sof(esof), .enc_eof(eeof), .enc_done(ed), .rx_valid(rv), .rx_data(rd),
        .rx_end(re), .rx_status(rs), .ram_we(we), .ram_addr(wa), .ram_wdata(wd), .seq_state(st),
        .initiator_mode(init));
    tcc_far_model u_tcc_far_model (.clk(clk), .reset_n(reset_n), .enc_start(es), .enc_data(edat),
        .enc_sof(esof), .enc_eof(eeof), .enc_done(ed), .frames(frames), .last_byte(lastb));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end
    always @(posedge clk) if (we === 1'b1) ram_q.push_back({wa, wd});

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a missing answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(negedge clk);
    endtask : apb

    // Drive one sequencer condition and wait for the state it should reach
    task automatic step(input int k, input logic [5:0] x, input logic [7:0] d = 8'h00, input logic l = 1'b1);
        int n;
        @(posedge clk);
        case (k)
            0: stop <= 1'b1;
            1: start <= 1'b1;
            2: {tg, sreq} <= 2'b11;
            3: {tv, td, tl} <= {1'b1, d, l};
            4: rg <= 1'b1;
            5: {rv, rd} <= {1'b1, d};
            default: {re, rs} <= {1'b1, d};
        endcase
        @(posedge clk);
        {stop, start, rv, re} <= 4'h0;
        rd <= ~rd;
        n = 0;
        while (st !== x && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(st, x);
        @(posedge clk);
        {tg, sreq, tv, rg} <= 4'h0;
    endtask : step

    task automatic rxb(input logic [7:0] d);
        @(posedge clk);
        {rv, rd} <= {1'b1, d};
        @(posedge clk);
        {rv, rd} <= {1'b0, ~d};
    endtask : rxb

    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {start, stop, sreq, tg, rg, tv, tl, td, rv, rd, re, rs} = '0;
        reset_n = 1'b0;
        rows = '{'{0, 8'h10, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h08, 0, 0, 0}, '{1, 8'h10, 32'h3fe, 0, 0},
            '{0, 8'h10, 0, 32'h3fe, 0}, '{1, 8'h08, 32'h20, 0, 0}, '{0, 8'h08, 0, 0, 0}, '{0, 8'h0c, 0, 0, 0},
            '{1, 8'h1c, 32'hff, 0, 1}, '{0, 8'h1c, 0, 0, 1}, '{1, 8'h04, 32'h23, 0, 0}, '{0, 8'h06, 0, 0, 1},
            '{0, 8'h04, 0, 32'h23, 0}};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(r, rows[i].x);
            chk(e, rows[i].e);
        end
        $display("register table done");
        apb(1, 8'h04, 32'h20);
        for (int i = 0; i < 7; i++) begin
            apb(1, 8'h0c, 32'h23);
            chk(irq, 0);
            apb(1, 8'h10, (i < 6) ? (32'h1 | (32'h10 << i)) : 32'h1);
            for (int k = 1; k < 7; k++) begin
                step(k, 6'h01 << (k % 6));
                chk(irq, (i == 6) ? 0 : (i == 0) ? (k == 6) : (k >= i));
            end
        end
        $display("state select done");
        apb(1, 8'h04, 32'h0);
        apb(1, 8'h10, 32'h21);
        chk(init, 1);
        step(1, 6'h02);
        chk(irq, 0);
        apb(0, 8'h08, 0);
        chk(r & 32'h20, 32'h20);
        apb(1, 8'h04, 32'h20);
        chk(irq, 1);
        apb(1, 8'h0c, 32'h20);
        chk(irq, 0);
        apb(0, 8'h08, 0);
        chk(r & 32'h20, 0);
        step(0, 6'h01);
        apb(1, 8'h10, 32'h0);
        chk(init, 0);
        step(1, 6'h08);
        step(0, 6'h01);
        $display("interrupt and role done");
        apb(1, 8'h10, 32'h9);
        f0 = frames;
        step(1, 6'h02);
        step(2, 6'h08);
        chk(frames - f0, 0);
        apb(0, 8'h10, 0);
        chk(r, 32'h1);
        step(0, 6'h01);
        $display("skip done");
        apb(1, 8'h10, 32'h5);
        f0 = frames;
        step(1, 6'h02);
        step(2, 6'h04);
        chk(txr, 1);
        step(3, 6'h02, 8'ha5, 1'b0);
        chk(txr, 0);
        step(2, 6'h04);
        step(3, 6'h08, 8'h3c, 1'b1);
        chk(frames - f0, 2);
        chk(lastb, 8'h3c);
        step(0, 6'h01);
        $display("framestep done");
        apb(1, 8'h10, 32'h3);
        ram_q.delete();
        step(1, 6'h02);
        step(2, 6'h04);
        step(3, 6'h08, 8'h77);
        step(4, 6'h10);
        step(5, 6'h20, 8'hee);
        rxb(8'ha1);
        rxb(8'hb2);
        rxb(8'hc3);
        step(6, 6'h10, 8'h5a);
        step(5, 6'h20, 8'hee);
        rxb(8'hd4);
        step(6, 6'h10, 8'h6b);
        repeat (3) @(posedge clk);
        chk(ram_q.size(), 2);
        chk(ram_q[0], {8'h00, 32'h5ac3b2a1});
        chk(ram_q[1], {8'h01, 32'h00006bd4});
        step(0, 6'h01);
        $display("repeat receive done");
        step(1, 6'h02);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({st, init, irq, we}, {6'h01, 3'h0});
        chk(prdata, 0);
        apb(0, 8'h10, 0);
        chk(r, 0);
        apb(0, 8'h04, 0);
        chk(r, 0);
        $display("reset done");
        apb(1, 8'h10, 32'h1);
        ram_q.delete();
        for (int k = 1; k < 6; k++) begin
            step(k, 6'h01 << k);
        end
        rxb(8'h9e);
        step(6, 6'h01);
        repeat (3) @(posedge clk);
        chk(ram_q.size(), 1);
        chk(ram_q[0], {8'h00, 32'h0000009e});
        $display("flush done");
        conclude();
    end
endmodule : tcc_transceive_ctrl_tb
